// >>> logic/thd_volt_bank.v
// read-only register bank for phase-to-phase voltage distortion
// assumes measurement inputs and register port run on I_MCLK
//
// Contract
// RULE1: registers are 16 bits, one address each
// RULE2: wide values span consecutive registers
// RULE3: most significant word at base address
// RULE4: single floats kept in IEEE layout
// RULE5: doubles use same most-significant-first order
// RULE6: instantaneous values at 0x006A, 0x006C, 0x006E
// RULE7: peaks with time at 0x0326, 0x032C, 0x0332
// RULE8: floors with time at 0x0526, 0x052C, 0x0532
// RULE9: master reads whole span from base
// RULE10: doubles span base to base plus three
// RULE11: no valid value reads as all FF
// RULE12: peak and floor follow reading, stamp time
// RULE13: writes to measurement registers are ignored
`timescale 1ns/1ps
`include "thd_consts.vh"

module thd_volt_bank (
  input wire I_MCLK,
  input wire I_RST,
  input wire I_MEAS_STB,
  input wire [2:0] I_MEAS_OK,
  input wire [31:0] I_THD_AB,
  input wire [31:0] I_THD_BC,
  input wire [31:0] I_THD_CA,
  input wire [63:0] I_EVENT_TIME,
  input wire I_EXTREME_CLR,
  input wire I_REG_RD,
  input wire I_REG_WR,
  input wire [15:0] I_REG_ADDR,
  input wire [15:0] I_REG_WDATA,
  output reg [15:0] O_REG_RDATA,
  output reg O_REG_ACK,
  output reg O_REG_ERR
);

  // ----------------------------------------------------------------
  // word selection, most significant register first
  // ----------------------------------------------------------------
  // a 64-bit unit (double_float_format or event_time_format) spans
  // four registers; a 32-bit unit sits in the upper half, two registers
  function [15:0] span_word;
    input [63:0] unit;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: span_word = unit[63:48]; // [RULE3] [RULE5] [RULE10]
        2'd1: span_word = unit[47:32];
        2'd2: span_word = unit[31:16];
        2'd3: span_word = unit[15:0];
        default: span_word = `THD_INVALID_WORD;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // per phase pair tracking and decode
  // ----------------------------------------------------------------
  wire [95:0] meas_bus = {I_THD_CA, I_THD_BC, I_THD_AB};
  wire [2:0] hit_vec;
  wire [47:0] word_bus;

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pair
      wire [15:0] now_base = (p == 0) ? `THD_VOLT_AB_NOW :
        (p == 1) ? `THD_VOLT_BC_NOW : `THD_VOLT_CA_NOW; // [RULE6]
      wire [15:0] peak_base = (p == 0) ? `THD_VOLT_AB_PEAK :
        (p == 1) ? `THD_VOLT_BC_PEAK : `THD_VOLT_CA_PEAK; // [RULE7]
      wire [15:0] floor_base = (p == 0) ? `THD_VOLT_AB_FLOOR :
        (p == 1) ? `THD_VOLT_BC_FLOOR : `THD_VOLT_CA_FLOOR; // [RULE8]
      wire [31:0] now_val;
      wire [31:0] peak_val;
      wire [63:0] peak_time;
      wire [31:0] floor_val;
      wire [63:0] floor_time;
      wire [15:0] now_ofs = I_REG_ADDR - now_base;
      wire [15:0] peak_ofs = I_REG_ADDR - peak_base;
      wire [15:0] floor_ofs = I_REG_ADDR - floor_base;
      wire now_hit = (now_ofs < `THD_NOW_SPAN); // [RULE2]
      wire peak_hit = (peak_ofs < `THD_EXT_SPAN); // [RULE2]
      wire floor_hit = (floor_ofs < `THD_EXT_SPAN); // [RULE2]
      wire [15:0] peak_tofs = peak_ofs - `THD_EXT_TIME_OFS;
      wire [15:0] floor_tofs = floor_ofs - `THD_EXT_TIME_OFS;
      reg [15:0] word;

      thd_extreme_track u_track (
        .clk(I_MCLK),
        .rst(I_RST),
        .stb(I_MEAS_STB),
        .ok(I_MEAS_OK[p]),
        .clr(I_EXTREME_CLR),
        .value(meas_bus[32*p+31:32*p]), // [RULE4]
        .stamp(I_EVENT_TIME),
        .now_reg(now_val),
        .peak_reg(peak_val),
        .peak_time_reg(peak_time),
        .floor_reg(floor_val),
        .floor_time_reg(floor_time)
      );

      always @* begin
        word = `THD_INVALID_WORD;
        if (now_hit) begin
          word = span_word({now_val, 32'h00000000}, now_ofs[1:0]); // [RULE4]
        end else if (peak_hit) begin
          if (peak_ofs < `THD_EXT_TIME_OFS) begin
            word = span_word({peak_val, 32'h00000000}, peak_ofs[1:0]);
          end else begin
            word = span_word(peak_time, peak_tofs[1:0]); // [RULE7]
          end
        end else if (floor_hit) begin
          if (floor_ofs < `THD_EXT_TIME_OFS) begin
            word = span_word({floor_val, 32'h00000000}, floor_ofs[1:0]);
          end else begin
            word = span_word(floor_time, floor_tofs[1:0]); // [RULE8]
          end
        end
      end

      assign hit_vec[p] = now_hit | peak_hit | floor_hit;
      assign word_bus[16*p+15:16*p] = word;
    end
  endgenerate

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  reg [15:0] sel_word;
  integer k;

  always @* begin
    sel_word = `THD_INVALID_WORD; // [RULE11]
    for (k = 0; k < 3; k = k + 1) begin
      if (hit_vec[k]) begin
        sel_word = word_bus[16*k +: 16];
      end
    end
  end

  wire any_hit = |hit_vec;

  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_REG_RDATA <= `THD_RDATA_RST;
      O_REG_ACK <= 1'b0;
      O_REG_ERR <= 1'b0;
    end else begin
      O_REG_ACK <= I_REG_RD | I_REG_WR;
      O_REG_ERR <= I_REG_WR | (I_REG_RD & ~any_hit); // [RULE13]
      if (I_REG_RD) begin
        O_REG_RDATA <= any_hit ? sel_word : `THD_INVALID_WORD; // [RULE1] [RULE9]
      end
    end
  end

endmodule // thd_volt_bank

// >>> logic/thd_consts.vh
// constants for the phase-to-phase voltage distortion register bank
// assumes 16-bit register addresses and a 10 MHz clock
`ifndef THD_CONSTS_VH
`define THD_CONSTS_VH

// ----------------------------------------------------------------
// register layout
// ----------------------------------------------------------------
`define THD_REG_W 16
`define THD_RDATA_RST 16'h0000
`define THD_INVALID_WORD 16'hFFFF
`define THD_INVALID_FLOAT 32'hFFFFFFFF
`define THD_INVALID_TIME 64'hFFFFFFFFFFFFFFFF
`define THD_NOW_SPAN 16'h0002
`define THD_EXT_SPAN 16'h0006
`define THD_EXT_TIME_OFS 16'h0002

// ----------------------------------------------------------------
// base register addresses
// ----------------------------------------------------------------
`define THD_VOLT_AB_NOW 16'h006A
`define THD_VOLT_BC_NOW 16'h006C
`define THD_VOLT_CA_NOW 16'h006E
`define THD_VOLT_AB_PEAK 16'h0326
`define THD_VOLT_BC_PEAK 16'h032C
`define THD_VOLT_CA_PEAK 16'h0332
`define THD_VOLT_AB_FLOOR 16'h0526
`define THD_VOLT_BC_FLOOR 16'h052C
`define THD_VOLT_CA_FLOOR 16'h0532

`endif

// >>> logic/thd_extreme_track.v
// one phase pair: latest reading plus peak and floor with event time
// assumes value and strobe come from logic on the same clock
`timescale 1ns/1ps
`include "thd_consts.vh"

module thd_extreme_track (
  input wire clk,
  input wire rst,
  input wire stb,
  input wire ok,
  input wire clr,
  input wire [31:0] value,
  input wire [63:0] stamp,
  output reg [31:0] now_reg,
  output reg [31:0] peak_reg,
  output reg [63:0] peak_time_reg,
  output reg [31:0] floor_reg,
  output reg [63:0] floor_time_reg
);

  // ----------------------------------------------------------------
  // capture and compare
  // ----------------------------------------------------------------
  // non-negative single floats order like unsigned integers
  wire usable = ok && !value[31];
  wire peak_none = (peak_reg == `THD_INVALID_FLOAT);
  wire floor_none = (floor_reg == `THD_INVALID_FLOAT);
  wire peak_hit = stb && usable && (peak_none || value > peak_reg);
  wire floor_hit = stb && usable && (floor_none || value < floor_reg);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      now_reg <= `THD_INVALID_FLOAT;
      peak_reg <= `THD_INVALID_FLOAT;
      peak_time_reg <= `THD_INVALID_TIME;
      floor_reg <= `THD_INVALID_FLOAT;
      floor_time_reg <= `THD_INVALID_TIME;
    end else begin
      if (stb) begin
        now_reg <= usable ? value : `THD_INVALID_FLOAT; // [RULE11]
      end
      if (peak_hit) begin
        peak_reg <= value; // [RULE12]
        peak_time_reg <= stamp; // [RULE12]
      end else if (clr) begin
        peak_reg <= `THD_INVALID_FLOAT; // [RULE11]
        peak_time_reg <= `THD_INVALID_TIME;
      end
      if (floor_hit) begin
        floor_reg <= value; // [RULE12]
        floor_time_reg <= stamp; // [RULE12]
      end else if (clr) begin
        floor_reg <= `THD_INVALID_FLOAT; // [RULE11]
        floor_time_reg <= `THD_INVALID_TIME;
      end
    end
  end

endmodule // thd_extreme_track

// >>> verif/thd_master.sv
// master model polling the distortion register bank
// assumes the bank answers one cycle after the request edge
`timescale 1ns/1ps
module thd_master (
  input wire clk,
  input wire [15:0] rdata,
  input wire ack,
  input wire err,
  output reg rd = 1'h0,
  output reg wr = 1'h0,
  output reg [15:0] addr = 16'h0000,
  output reg [15:0] wdata = 16'h0000
);
  task xfer(input w, input [15:0] a, output [15:0] d, output e);
    @(negedge clk);
    {rd, wr, addr, wdata} = {~w, w, a, 16'h5A5A};
    @(negedge clk);
    {rd, wr, addr, wdata} = {2'h0, ~a, 16'hA5A5};
    d = ack ? rdata : 16'hXXXX;
    e = ack ? err : 1'hX;
  endtask
  task read32(input [15:0] a, output [31:0] v, output e);
    reg e1;
    xfer(1'h0, a, v[31:16], e1);
    xfer(1'h0, a + 16'h0001, v[15:0], e);
    e = e | e1;
  endtask
endmodule // thd_master

// >>> verif/thd_volt_bank_chk.sv
// assertions on the distortion register bank ports
// bound onto thd_volt_bank below
`timescale 1ns/1ps
module thd_chk (
  input wire I_MCLK,
  input wire I_RST,
  input wire I_MEAS_STB,
  input wire [2:0] I_MEAS_OK,
  input wire [31:0] I_THD_AB,
  input wire I_REG_RD,
  input wire I_REG_WR,
  input wire [15:0] I_REG_ADDR,
  input wire [15:0] O_REG_RDATA,
  input wire O_REG_ACK,
  input wire O_REG_ERR
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  wire req = I_REG_RD | I_REG_WR;
  wire rd = I_REG_RD & ~I_REG_WR;
  wire [15:0] a = I_REG_ADDR;
  wire map = (a >= 16'h006A && a <= 16'h006F) || (a >= 16'h0326 && a <= 16'h0337)
    || (a >= 16'h0526 && a <= 16'h0537);
  sequence s_ab(bit v);
    I_MEAS_STB && I_MEAS_OK[0] == v && !I_THD_AB[31] ##1 !I_MEAS_STB
    ##1 rd && !I_MEAS_STB && a == 16'h006A;
  endsequence
  a_ack_on_req: assert property (req |=> O_REG_ACK) else $error("no ack");
  a_ack_only_req: assert property (!req |=> !O_REG_ACK) else $error("stray ack");
  a_err_with_ack: assert property (O_REG_ERR |-> O_REG_ACK) else $error("lone err");
  a_write_refused: assert property (I_REG_WR |=> O_REG_ERR) else $error("write taken");
  a_rdata_held: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
    else $error("data moved");
  a_mapped_ok: assert property (rd && map |=> !O_REG_ERR) else $error("mapped err");
  a_gap_ff: assert property (I_REG_RD && !map |=> O_REG_ERR && O_REG_RDATA == 16'hFFFF)
    else $error("unmapped read");
  a_high_first: assert property (s_ab(1'h1) |=> O_REG_RDATA == $past(I_THD_AB[31:16], 3))
    else $error("high half wrong");
  a_invalid_ff: assert property (s_ab(1'h0) |=> O_REG_RDATA == 16'hFFFF)
    else $error("invalid not ff");
endmodule // thd_chk
bind thd_volt_bank thd_chk i_chk (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_MEAS_STB(I_MEAS_STB),
  .I_MEAS_OK(I_MEAS_OK), .I_THD_AB(I_THD_AB), .I_REG_RD(I_REG_RD), .I_REG_WR(I_REG_WR),
  .I_REG_ADDR(I_REG_ADDR), .O_REG_RDATA(O_REG_RDATA), .O_REG_ACK(O_REG_ACK),
  .O_REG_ERR(O_REG_ERR));

// >>> verif/testbench.sv
// self-checking bench for the distortion register bank
// assumes thd_master and the bound checker are compiled first
`timescale 1ns/1ps
`include "thd_consts.vh"
module testbench;
  localparam [31:0] f1 = 32'h3F800000, f10 = 32'h41200000, f100 = 32'h42C80000;
  localparam [63:0] t1 = 64'h0000000100000000, t2 = 64'h0000000280000000;
  reg mclk = 1'h0, rst = 1'h1, stb = 1'h0, clr = 1'h0, e;
  reg [2:0] ok = 3'h0;
  reg [31:0] ab = 32'h0, bc = 32'h0, ca = 32'h0, v;
  reg [63:0] tm = 64'h0, tv;
  reg [15:0] d;
  wire rd, wr, ack, err;
  wire [15:0] addr, wdata, rdata;
  integer fail_count = 0, n_tests = 0;
  always #50 mclk = ~mclk;
  thd_volt_bank i_dut (.I_MCLK(mclk), .I_RST(rst), .I_MEAS_STB(stb), .I_MEAS_OK(ok),
    .I_THD_AB(ab), .I_THD_BC(bc), .I_THD_CA(ca), .I_EVENT_TIME(tm), .I_EXTREME_CLR(clr),
    .I_REG_RD(rd), .I_REG_WR(wr), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .O_REG_ACK(ack), .O_REG_ERR(err));
  thd_master i_mst (.clk(mclk), .rdata(rdata), .ack(ack), .err(err), .rd(rd), .wr(wr),
    .addr(addr), .wdata(wdata));
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cmp(input string nm, input [63:0] x, input [63:0] g);
    n_tests = n_tests + 1;
    if (g !== x) begin
      fail_count = fail_count + 1;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task meas(input [2:0] o, input [31:0] a, b, c, input [63:0] t);
    @(negedge mclk);
    {stb, ok, ab, bc, ca, tm} = {1'h1, o, a, b, c, t};
    @(negedge mclk);
    stb = 1'h0;
  endtask
  task chk(input string nm, input [15:0] a, input [31:0] x);
    i_mst.read32(a, v, e);
    cmp(nm, {1'h0, x}, {e, v});
  endtask
  task chkx(input string nm, input [15:0] a, input [31:0] x, input [63:0] t);
    chk(nm, a, x);
    i_mst.read32(a + 16'h0002, tv[63:32], e);
    i_mst.read32(a + 16'h0004, tv[31:0], e);
    cmp(nm, t, tv);
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'h0;
    chk("idle", `THD_VOLT_AB_NOW, 32'hFFFFFFFF);
    $display("test reset done");
    meas(3'h7, f10, f10, f10, t1);
    meas(3'h7, f100, f1, f10, t2);
    chk("now ab", `THD_VOLT_AB_NOW, f100);
    chk("now bc", `THD_VOLT_BC_NOW, f1);
    chk("now ca", `THD_VOLT_CA_NOW, f10);
    chkx("peak ab", `THD_VOLT_AB_PEAK, f100, t2);
    chkx("peak bc", `THD_VOLT_BC_PEAK, f10, t1);
    chkx("peak ca", `THD_VOLT_CA_PEAK, f10, t1);
    chkx("floor ab", `THD_VOLT_AB_FLOOR, f10, t1);
    chkx("floor bc", `THD_VOLT_BC_FLOOR, f1, t2);
    $display("test tracking done");
    meas(3'h6, f1, f1, f1, t2 + t1);
    chk("bad ab", `THD_VOLT_AB_NOW, 32'hFFFFFFFF);
    chkx("floor ab kept", `THD_VOLT_AB_FLOOR, f10, t1);
    chkx("floor ca", `THD_VOLT_CA_FLOOR, f1, t2 + t1);
    i_mst.xfer(1'h1, `THD_VOLT_BC_NOW, d, e);
    cmp("write err", 1'h1, e);
    chk("bc kept", `THD_VOLT_BC_NOW, f1);
    i_mst.xfer(1'h0, 16'h0070, d, e);
    cmp("gap", 17'h1FFFF, {e, d});
    @(negedge mclk);
    clr = 1'h1;
    @(negedge mclk);
    clr = 1'h0;
    chkx("cleared", `THD_VOLT_AB_PEAK, 32'hFFFFFFFF, 64'hFFFFFFFFFFFFFFFF);
    // clear and new sample in one cycle: the sample wins
    fork
      meas(3'h7, f10, f10, f10, t1);
      begin
        @(negedge mclk);
        clr = 1'h1;
        @(negedge mclk);
        clr = 1'h0;
      end
    join
    chkx("clr race peak", `THD_VOLT_AB_PEAK, f10, t1);
    chkx("clr race floor", `THD_VOLT_AB_FLOOR, f10, t1);
    $display("test access done");
    summarize;
  end
  initial begin
    #500000;
    fail_count = fail_count + 1;
    summarize;
  end
endmodule // testbench
